// ### core/asf_regs.vh
`ifndef ASF_REGS_VH
`define ASF_REGS_VH

// Flag positions inside the arithmetic_flags register
`define ASF_BIT_CARRY       0
`define ASF_BIT_NIBBLE      1
`define ASF_BIT_ZERO        2
`define ASF_BIT_WRAP        3
`define ASF_BIT_MSB         4
`define ASF_FLAG_MSB        4
`define ASF_FLAG_W          5
`define ASF_UNIMP_W         3

// Reset value of the flags (held at zero so state is defined)
`define ASF_FLAGS_RESET     5'h00
`define ASF_UNIMP_VALUE     3'h0
`define ASF_BYTE_ZERO       8'h00

// Operation codes presented on op_code
`define ASF_OP_W            5
`define ASF_OP_NOP          5'h00
`define ASF_OP_ADD_WF       5'h01
`define ASF_OP_ADD_LIT      5'h02
`define ASF_OP_SUB_LIT      5'h03
`define ASF_OP_SUB_WF       5'h04
`define ASF_OP_ROT_RIGHT    5'h05
`define ASF_OP_ROT_LEFT     5'h06
`define ASF_OP_AND          5'h07
`define ASF_OP_IOR          5'h08
`define ASF_OP_XOR          5'h09
`define ASF_OP_MOVE_F       5'h0A
`define ASF_OP_CLEAR_F      5'h0B
`define ASF_OP_BIT_CLEAR    5'h0C
`define ASF_OP_BIT_SET      5'h0D
`define ASF_OP_SWAP         5'h0E
`define ASF_OP_MOVE_FF      5'h0F
`define ASF_OP_MOVE_WF      5'h10

// Flag-update masks, one bit per flag position
`define ASF_MASK_NONE       5'h00
`define ASF_MASK_ARITH      5'h1F
`define ASF_MASK_ROT        5'h17
`define ASF_MASK_NZ         5'h14
`define ASF_MASK_Z          5'h04

// Addressing modes reported on addr_mode
`define ASF_MODE_W          3
`define ASF_MODE_INHERENT   3'h0
`define ASF_MODE_LITERAL    3'h1
`define ASF_MODE_DIRECT     3'h2
`define ASF_MODE_INDIRECT   3'h3
`define ASF_MODE_INDEXED    3'h4

// Access-bank offsets below this use indexed mode when enabled
`define ASF_INDEX_LIMIT     8'h60

`endif

// ### core/asf_status_flags.v
`timescale 1ns/10ps
`default_nettype none
`include "asf_regs.vh"

module asf_status_flags (
   input  wire                    ref_clk,
   input  wire                    rst,
   input  wire                    op_valid,
   input  wire [`ASF_OP_W-1:0]    op_code,
   input  wire [7:0]              w_operand,
   input  wire [7:0]              src_operand,
   input  wire [2:0]              bit_sel,
   input  wire                    dest_is_status,
   input  wire                    op_has_file,
   input  wire                    op_has_literal,
   input  wire                    file_indirect,
   input  wire                    access_bank_sel,
   input  wire [7:0]              file_addr,
   input  wire                    extended_set_enable,
   output reg  [7:0]              arithmetic_flags,
   output reg  [7:0]              result_q,
   output reg                     result_wr_q,
   output reg  [`ASF_MODE_W-1:0]  addr_mode_q
);

   reg  [`ASF_FLAG_W-1:0]   flags_q;
   reg  [`ASF_FLAG_W-1:0]   flags_d;
   reg  [`ASF_FLAG_W-1:0]   calc_flags;
   reg  [`ASF_FLAG_W-1:0]   upd_mask;
   reg  [7:0]               res_d;
   reg  [7:0]               add_a;
   reg  [7:0]               add_b;
   reg                      add_cin;
   reg                      is_adder;
   reg                      is_rotate;
   reg  [`ASF_MODE_W-1:0]   mode_d;
   wire [8:0]               full_sum;
   wire [4:0]               low_sum;
   wire                     wr_d;
   wire [7:0]               bit_onehot;
   wire                     carry_now;

   assign carry_now  = flags_q[`ASF_BIT_CARRY];
   assign bit_onehot = 8'h01 << bit_sel;

   // Subtraction runs through the same adder with the operand inverted
   // and a carry-in of one, so both carries come out as not-borrow.
   assign full_sum = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
   assign low_sum  = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};

   // Operand selection and raw result
   always @* begin
      add_a     = w_operand;
      add_b     = src_operand;
      add_cin   = 1'b0;
      is_adder  = 1'b0;
      is_rotate = 1'b0;
      res_d     = `ASF_BYTE_ZERO;
      upd_mask  = `ASF_MASK_NONE;
      case (op_code)
         `ASF_OP_ADD_WF,
         `ASF_OP_ADD_LIT: begin
            is_adder = 1'b1;
            res_d    = full_sum[7:0];
            upd_mask = `ASF_MASK_ARITH;
         end
         `ASF_OP_SUB_LIT: begin
            // Literal minus W; literal arrives on src_operand
            add_a    = src_operand;
            add_b    = ~w_operand;
            add_cin  = 1'b1;
            is_adder = 1'b1;
            res_d    = full_sum[7:0];
            upd_mask = `ASF_MASK_ARITH;
         end
         `ASF_OP_SUB_WF: begin
            add_a    = src_operand;
            add_b    = ~w_operand;
            add_cin  = 1'b1;
            is_adder = 1'b1;
            res_d    = full_sum[7:0];
            upd_mask = `ASF_MASK_ARITH;
         end
         `ASF_OP_ROT_RIGHT: begin
            is_rotate = 1'b1;
            res_d     = {carry_now, src_operand[7:1]};
            upd_mask  = `ASF_MASK_ROT;
         end
         `ASF_OP_ROT_LEFT: begin
            is_rotate = 1'b1;
            res_d     = {src_operand[6:0], carry_now};
            upd_mask  = `ASF_MASK_ROT;
         end
         `ASF_OP_AND: begin
            res_d    = w_operand & src_operand;
            upd_mask = `ASF_MASK_NZ;
         end
         `ASF_OP_IOR: begin
            res_d    = w_operand | src_operand;
            upd_mask = `ASF_MASK_NZ;
         end
         `ASF_OP_XOR: begin
            res_d    = w_operand ^ src_operand;
            upd_mask = `ASF_MASK_NZ;
         end
         `ASF_OP_MOVE_F: begin
            res_d    = src_operand;
            upd_mask = `ASF_MASK_NZ;
         end
         `ASF_OP_CLEAR_F: begin
            // Only zero is touched, so aimed at status the rest stay
            res_d    = `ASF_BYTE_ZERO;
            upd_mask = `ASF_MASK_Z;
         end
         `ASF_OP_BIT_CLEAR: begin
            res_d    = src_operand & ~bit_onehot;
            upd_mask = `ASF_MASK_NONE;
         end
         `ASF_OP_BIT_SET: begin
            res_d    = src_operand | bit_onehot;
            upd_mask = `ASF_MASK_NONE;
         end
         `ASF_OP_SWAP: begin
            res_d    = {src_operand[3:0], src_operand[7:4]};
            upd_mask = `ASF_MASK_NONE;
         end
         `ASF_OP_MOVE_FF: begin
            res_d    = src_operand;
            upd_mask = `ASF_MASK_NONE;
         end
         `ASF_OP_MOVE_WF: begin
            res_d    = w_operand;
            upd_mask = `ASF_MASK_NONE;
         end
         default: begin
            res_d    = `ASF_BYTE_ZERO;
            upd_mask = `ASF_MASK_NONE;
         end
      endcase
   end

   // Candidate flag values from the result
   always @* begin
      calc_flags = flags_q;
      calc_flags[`ASF_BIT_MSB]  = res_d[7];
      calc_flags[`ASF_BIT_ZERO] = (res_d == `ASF_BYTE_ZERO);
      if (is_adder) begin
         // Operands share a sign the result lacks
         calc_flags[`ASF_BIT_WRAP]   = (add_a[7] == add_b[7]) &&
                                       (full_sum[7] != add_a[7]);
         calc_flags[`ASF_BIT_NIBBLE] = low_sum[4];
         calc_flags[`ASF_BIT_CARRY]  = full_sum[8];
      end else if (is_rotate) begin
         if (op_code == `ASF_OP_ROT_RIGHT) begin
            calc_flags[`ASF_BIT_NIBBLE] = src_operand[4];
            calc_flags[`ASF_BIT_CARRY]  = src_operand[0];
         end else begin
            calc_flags[`ASF_BIT_NIBBLE] = src_operand[3];
            calc_flags[`ASF_BIT_CARRY]  = src_operand[7];
         end
      end
   end

   // Status update: the flag update wins over the written result
   always @* begin
      flags_d = flags_q;
      if (op_valid) begin
         if (dest_is_status && (upd_mask == `ASF_MASK_NONE)) begin
            // Plain write of status; upper bits are dropped
            flags_d = res_d[`ASF_FLAG_MSB:0];
         end else begin
            flags_d = (calc_flags & upd_mask) |
                      (flags_q & ~upd_mask);
         end
      end
   end

   // The result goes out on a valid non-NOP op unless status took the flag update instead
   assign wr_d = op_valid && (op_code != `ASF_OP_NOP) &&
                 !(dest_is_status && (upd_mask != `ASF_MASK_NONE));

   // Data addressing mode of the current instruction
   always @* begin
      mode_d = `ASF_MODE_INHERENT;
      if (op_has_file) begin
         if (file_indirect) begin
            mode_d = `ASF_MODE_INDIRECT;
         end else if (extended_set_enable && !access_bank_sel &&
                      (file_addr < `ASF_INDEX_LIMIT)) begin
            mode_d = `ASF_MODE_INDEXED;
         end else begin
            mode_d = `ASF_MODE_DIRECT;
         end
      end else if (op_has_literal) begin
         mode_d = `ASF_MODE_LITERAL;
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flags_q          <= `ASF_FLAGS_RESET;
         arithmetic_flags <= {`ASF_UNIMP_VALUE, `ASF_FLAGS_RESET};
         result_q         <= `ASF_BYTE_ZERO;
         result_wr_q      <= 1'b0;
         addr_mode_q      <= `ASF_MODE_INHERENT;
      end else begin
         flags_q          <= flags_d;
         arithmetic_flags <= {`ASF_UNIMP_VALUE, flags_d};
         result_q         <= res_d;
         result_wr_q      <= wr_d;
         addr_mode_q      <= mode_d;
      end
   end

endmodule

`default_nettype wire

// ### verification/asf_status_flags_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "asf_regs.vh"
module asf_status_flags_props (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       op_valid,
   input wire logic [4:0] op_code,
   input wire logic [7:0] w_operand,
   input wire logic [7:0] src_operand,
   input wire logic [2:0] bit_sel,
   input wire logic       dest_is_status,
   input wire logic       op_has_file,
   input wire logic       op_has_literal,
   input wire logic       file_indirect,
   input wire logic       access_bank_sel,
   input wire logic [7:0] file_addr,
   input wire logic       extended_set_enable,
   input wire logic [7:0] arithmetic_flags,
   input wire logic [7:0] result_q,
   input wire logic       result_wr_q,
   input wire logic [2:0] addr_mode_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Add and subtract codes sit in one contiguous range
   wire logic arith = op_valid && op_code >= `ASF_OP_ADD_WF && op_code <= `ASF_OP_SUB_WF;
   wire logic quiet = op_valid && op_code >= `ASF_OP_BIT_CLEAR && op_code <= `ASF_OP_MOVE_WF;
   a_upper_bits_zero: assert property (arithmetic_flags[7:5] == 3'h0)
      else $error("upper status bits not zero");
   a_msb_flag_sign: assert property (arith && !dest_is_status |=> arithmetic_flags[4] == result_q[7])
      else $error("negative flag does not follow result sign");
   a_zero_flag_result: assert property (arith && !dest_is_status |=> arithmetic_flags[2] == (result_q == 8'h00))
      else $error("zero flag does not follow result");
   a_add_nibble_carry: assert property (op_valid && op_code == `ASF_OP_ADD_WF |=>
      arithmetic_flags[1] == (($past(w_operand[3:0]) + $past(src_operand[3:0])) > 5'd15))
      else $error("digit carry wrong after add");
   a_add_top_carry: assert property (op_valid && op_code == `ASF_OP_ADD_WF |=>
      arithmetic_flags[0] == (({1'b0, $past(w_operand)} + $past(src_operand)) > 9'd255))
      else $error("carry wrong after add");
   a_add_signed_wrap: assert property (op_valid && op_code == `ASF_OP_ADD_WF |=>
      arithmetic_flags[3] == (($past(w_operand[7]) == $past(src_operand[7])) && (result_q[7] != $past(w_operand[7]))))
      else $error("overflow flag wrong after add");
   a_sub_no_borrow: assert property (op_valid && op_code == `ASF_OP_SUB_WF |=>
      arithmetic_flags[0] == ($past(src_operand) >= $past(w_operand)))
      else $error("carry is not the inverted borrow");
   a_rotate_right_load: assert property (op_valid && op_code == `ASF_OP_ROT_RIGHT && !dest_is_status |=>
      arithmetic_flags[1:0] == {$past(src_operand[4]), $past(src_operand[0])}
      && result_q == {$past(arithmetic_flags[0]), $past(src_operand[7:1])})
      else $error("rotate right loaded wrong bits");
   a_status_dest_drop: assert property (arith && dest_is_status |=> !result_wr_q)
      else $error("result written while status was destination");
   a_clear_status_z: assert property (op_valid && op_code == `ASF_OP_CLEAR_F && dest_is_status |=>
      arithmetic_flags == ($past(arithmetic_flags) | 8'h04))
      else $error("clear of status changed more than zero flag");
   a_quiet_ops_keep: assert property (quiet && !dest_is_status |=> $stable(arithmetic_flags))
      else $error("flags changed by a non-flag operation");
   a_idle_keeps_flags: assert property (!op_valid |=> $stable(arithmetic_flags) && !result_wr_q)
      else $error("flags or write changed with no operation");
   a_indexed_needs_ext: assert property (addr_mode_q == `ASF_MODE_INDEXED |-> $past(extended_set_enable))
      else $error("indexed mode without extended set");
endmodule
`default_nettype wire

// ### verification/asf_status_flags_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "asf_regs.vh"
module asf_status_flags_tb;
   logic        ref_clk, rst, op_valid, dest_is_status, op_has_file, op_has_literal;
   logic        file_indirect, access_bank_sel, extended_set_enable, result_wr_q;
   logic [4:0]  op_code;
   logic [7:0]  w_operand, src_operand, file_addr, arithmetic_flags, result_q;
   logic [2:0]  bit_sel, addr_mode_q;
   int          bad_count, n_tests;
   // Row: op, w, src, bit select, expected flags, expected result
   logic [36:0] rows [18];
   asf_status_flags dut (.*);
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic issue(input logic [4:0] op, input logic [7:0] w, input logic [7:0] s, input logic [2:0] sel,
                        input logic d);
      op_valid = 1'b1;
      op_code = op;
      w_operand = w;
      src_operand = s;
      bit_sel = sel;
      dest_is_status = d;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic mode(input logic f, input logic l, input logic ind, input logic ext, input logic [7:0] a,
                       input logic [2:0] exp);
      op_has_file = f;
      op_has_literal = l;
      file_indirect = ind;
      extended_set_enable = ext;
      file_addr = a;
      @(posedge ref_clk);
      #1;
      chk("addr_mode", {5'h00, exp}, {5'h00, addr_mode_q});
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      #100000;
      bad_count++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      {op_valid, dest_is_status, op_has_file, op_has_literal, file_indirect} = 5'h00;
      {access_bank_sel, extended_set_enable, op_code, bit_sel} = 10'h000;
      {w_operand, src_operand, file_addr} = 24'h00_0000;
      bad_count = 0;
      n_tests = 0;
      rows = '{{`ASF_OP_ADD_WF, 8'h0F, 8'h01, 3'h0, 5'h02, 8'h10}, {`ASF_OP_ADD_LIT, 8'h80, 8'h80, 3'h0, 5'h0D, 8'h00},
               {`ASF_OP_SUB_WF, 8'h06, 8'h05, 3'h0, 5'h10, 8'hFF}, {`ASF_OP_SUB_LIT, 8'h01, 8'h80, 3'h0, 5'h09, 8'h7F},
               {`ASF_OP_ROT_LEFT, 8'h00, 8'h88, 3'h0, 5'h0B, 8'h11}, {`ASF_OP_ROT_RIGHT, 8'h00, 8'h11, 3'h0, 5'h1B, 8'h88},
               {`ASF_OP_ROT_LEFT, 8'h00, 8'h00, 3'h0, 5'h08, 8'h01}, {`ASF_OP_ROT_RIGHT, 8'h00, 8'h00, 3'h0, 5'h0C, 8'h00},
               {`ASF_OP_AND, 8'hFF, 8'hF0, 3'h0, 5'h18, 8'hF0}, {`ASF_OP_IOR, 8'h00, 8'h00, 3'h0, 5'h0C, 8'h00},
               {`ASF_OP_XOR, 8'hFF, 8'h7F, 3'h0, 5'h18, 8'h80}, {`ASF_OP_CLEAR_F, 8'h00, 8'h55, 3'h0, 5'h1C, 8'h00},
               {`ASF_OP_MOVE_F, 8'h00, 8'h80, 3'h0, 5'h18, 8'h80}, {`ASF_OP_SWAP, 8'h00, 8'hA5, 3'h0, 5'h18, 8'h5A},
               {`ASF_OP_BIT_SET, 8'h00, 8'h00, 3'h2, 5'h18, 8'h04}, {`ASF_OP_BIT_CLEAR, 8'h00, 8'hFF, 3'h7, 5'h18, 8'h7F},
               {`ASF_OP_MOVE_FF, 8'h00, 8'hC3, 3'h0, 5'h18, 8'hC3}, {`ASF_OP_MOVE_WF, 8'h3C, 8'h00, 3'h0, 5'h18, 8'h3C}};
      repeat (8) @(posedge ref_clk);
      #1;
      chk("reset flags", 8'h00, arithmetic_flags);
      rst = 1'b0;
      foreach (rows[i]) begin
         issue(rows[i][36:32], rows[i][31:24], rows[i][23:16], rows[i][15:13], 1'b0);
         chk("flags", {3'h0, rows[i][12:8]}, arithmetic_flags);
         chk("result", rows[i][7:0], result_q);
         chk("write", 8'h01, {7'h00, result_wr_q});
      end
      op_valid = 1'b0;
      @(posedge ref_clk);
      #1;
      chk("idle flags", 8'h18, arithmetic_flags);
      chk("idle write", 8'h00, {7'h00, result_wr_q});
      issue(`ASF_OP_MOVE_WF, 8'hFF, 8'h00, 3'h0, 1'b1);
      chk("status write", 8'h1F, arithmetic_flags);
      issue(`ASF_OP_ADD_WF, 8'h01, 8'h01, 3'h0, 1'b1);
      chk("status add flags", 8'h00, arithmetic_flags);
      chk("status add write", 8'h00, {7'h00, result_wr_q});
      issue(`ASF_OP_MOVE_WF, 8'h1B, 8'h00, 3'h0, 1'b1);
      issue(`ASF_OP_CLEAR_F, 8'h00, 8'h00, 3'h0, 1'b1);
      chk("status clear", 8'h1F, arithmetic_flags);
      chk("status clear write", 8'h00, {7'h00, result_wr_q});
      op_valid = 1'b0;
      mode(1'b1, 1'b0, 1'b0, 1'b1, 8'h5F, `ASF_MODE_INDEXED);
      mode(1'b1, 1'b0, 1'b0, 1'b1, 8'h60, `ASF_MODE_DIRECT);
      mode(1'b1, 1'b0, 1'b0, 1'b0, 8'h10, `ASF_MODE_DIRECT);
      mode(1'b1, 1'b0, 1'b1, 1'b1, 8'h10, `ASF_MODE_INDIRECT);
      mode(1'b0, 1'b1, 1'b0, 1'b1, 8'h10, `ASF_MODE_LITERAL);
      mode(1'b0, 1'b0, 1'b0, 1'b1, 8'h10, `ASF_MODE_INHERENT);
      access_bank_sel = 1'b1;
      mode(1'b1, 1'b0, 1'b0, 1'b1, 8'h10, `ASF_MODE_DIRECT);
      rst = 1'b1;
      #1;
      chk("mid reset flags", 8'h00, arithmetic_flags);
      wrap_up();
   end
endmodule
bind asf_status_flags asf_status_flags_props props (.*);
`default_nettype wire
